// ### common/ccs_pkg.sv
/*
 Constants, register map and state carriers for the core clock scaling and
 oscillator pin control block.
 Assumes one 200 MHz clock, a synchronous active-low reset and AXI4-Lite access.
*/
// What this block does
// RULE_01: software keeps each new cpu frequency below four times the present one
// RULE_02: software waits at least 5 us between two cpu frequency changes
// RULE_03: range 1 runs 32 kHz-16 MHz at 0 wait states, to 32 MHz at one
// RULE_04: range 2 runs 32 kHz-8 MHz at 0 wait states, to 16 MHz at one
// RULE_05: range 3 runs 32 kHz-2.1 MHz at 0 wait states, to 4.2 MHz at one
// RULE_06: port c pins 14/15 serve the slow crystal only while its enable is set
// RULE_07: slow crystal function overrides gpio configuration of its two pins
// RULE_08: reset clears the slow crystal enable, pins return to gpio
// RULE_09: port h pins 0/1 serve the fast crystal only while its enable is set
// RULE_10: reset clears the fast crystal enable, pins return to gpio
// RULE_11: fast crystal function overrides gpio configuration of its two pins
// RULE_12: raise wait states before a faster clock, lower them after a slower one
package ccs_pkg;

   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_FREQ   = 4'h4;
   localparam logic [3:0]  ADDR_STATUS = 4'h8;

   // ctrl fields
   localparam int          CTRL_SLOW_BIT = 0;
   localparam int          CTRL_FAST_BIT = 1;
   localparam int          CTRL_RNG_LO   = 2;
   // status fields
   localparam int          ST_WS_BIT     = 16;
   localparam int          ST_BUSY_BIT   = 17;
   localparam int          ST_READY_BIT  = 18;
   localparam int          ST_ERR_LO     = 24;

   localparam logic [1:0]  RANGE_1 = 2'h1;
   localparam logic [1:0]  RANGE_2 = 2'h2;
   localparam logic [1:0]  RANGE_3 = 2'h3;

   // frequency limits in kHz
   localparam logic [15:0] KHZ_MIN      = 16'h0020;
   localparam logic [15:0] R1_ZERO_MAX  = 16'h3E80;
   localparam logic [15:0] R1_ONE_MAX   = 16'h7D00;
   localparam logic [15:0] R2_ZERO_MAX  = 16'h1F40;
   localparam logic [15:0] R2_ONE_MAX   = 16'h3E80;
   localparam logic [15:0] R3_ZERO_MAX  = 16'h0834;
   localparam logic [15:0] R3_ONE_MAX   = 16'h1068;

   localparam logic [15:0] RST_KHZ      = 16'h0834;
   localparam logic [1:0]  RST_RANGE    = 2'h1;

   localparam int          CLK_MHZ      = 200;
   localparam int          GAP_US       = 5;
   localparam int          GAP_CYCLES   = GAP_US * CLK_MHZ;
   localparam logic [9:0]  GAP_LOAD     = 10'(GAP_CYCLES);

   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [3:0] {
      SEQ_IDLE   = 4'h1,
      SEQ_RAISE  = 4'h2,
      SEQ_SWITCH = 4'h4,
      SEQ_SETTLE = 4'h8
   } ccs_seq_t;

   typedef struct packed {
      logic [1:0] pad_out;
      logic [1:0] pad_oe;
      logic [1:0] gpio_in;
      logic       fast_crystal_input;
      logic       osc_mode;
   } ccs_pin_t;

   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [3:0]  aw_addr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        slow_en;
      logic        fast_en;
      logic [1:0]  vrange;
      logic [15:0] cur_khz;
      logic [15:0] tgt_khz;
      logic        wait_state;
      logic        need_ws;
      ccs_seq_t    seq;
      logic [9:0]  gap_cnt;
      logic [2:0]  err;
   } ccs_state_t;

endpackage

// ### src/ccs_pin_mux.sv
/*
 Hands one pair of oscillator pins between gpio and a crystal oscillator.
 Assumes the pad ring resolves the wire from pad_out and pad_oe.
*/
`timescale 1ns/100ps
module ccs_pin_mux (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       osc_en,
   input  wire logic [1:0] gpio_out,
   input  wire logic [1:0] gpio_oe,
   input  wire logic [1:0] pad_in,
   input  wire logic       osc_drive,
   output ccs_pkg::ccs_pin_t pins
);

   ccs_pkg::ccs_pin_t r;
   ccs_pkg::ccs_pin_t next_r;

   always_comb begin
      next_r = r;
      if (osc_en) begin
         // oscillator wins regardless of the gpio setup
         next_r.pad_out  = {osc_drive, 1'b0};
         next_r.pad_oe   = 2'b10;
         next_r.gpio_in  = 2'b00;
         next_r.fast_crystal_input   = pad_in[0];
         next_r.osc_mode = 1'b1;
      end else begin
         next_r.pad_out  = gpio_out;
         next_r.pad_oe   = gpio_oe;
         next_r.gpio_in  = pad_in;
         next_r.fast_crystal_input   = 1'b0;
         next_r.osc_mode = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign pins = r;

endmodule

// ### src/ccs_top.sv
/*
 Core clock scaling and oscillator pin control with an AXI4-Lite register file.
 Assumes aclk at 200 MHz, synchronous active-low aresetn, one bus master.
*/
`timescale 1ns/100ps
module ccs_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [15:0]      core_khz,
   output logic             flash_wait_state,
   input  wire logic [1:0]  port_c_gpio_out,
   input  wire logic [1:0]  port_c_gpio_oe,
   input  wire logic [1:0]  port_c_pad_in,
   input  wire logic        slow_crystal_drive,
   output ccs_pkg::ccs_pin_t port_c_pins,
   input  wire logic [1:0]  port_h_gpio_out,
   input  wire logic [1:0]  port_h_gpio_oe,
   input  wire logic [1:0]  port_h_pad_in,
   input  wire logic        fast_crystal_drive,
   output ccs_pkg::ccs_pin_t port_h_pins
);

   ccs_pkg::ccs_state_t r;
   ccs_pkg::ccs_state_t next_r;

   // bit0 legal, bit1 one wait state needed
   function automatic logic [1:0] ws_of(input logic [1:0] rng, input logic [15:0] khz);
      logic [15:0] zmax;
      logic [15:0] omax;
      zmax = ccs_pkg::R1_ZERO_MAX;
      omax = ccs_pkg::R1_ONE_MAX;
      case (rng)
         ccs_pkg::RANGE_1: begin
            zmax = ccs_pkg::R1_ZERO_MAX; // RULE_03
            omax = ccs_pkg::R1_ONE_MAX;
         end
         ccs_pkg::RANGE_2: begin
            zmax = ccs_pkg::R2_ZERO_MAX; // RULE_04
            omax = ccs_pkg::R2_ONE_MAX;
         end
         ccs_pkg::RANGE_3: begin
            zmax = ccs_pkg::R3_ZERO_MAX; // RULE_05
            omax = ccs_pkg::R3_ONE_MAX;
         end
         default: begin
            zmax = 16'h0000;
            omax = 16'h0000;
         end
      endcase
      ws_of = {khz > zmax, (khz >= ccs_pkg::KHZ_MIN) && (khz <= omax)};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = res;
   endfunction

   logic        aw_hs;
   logic        w_hs;
   logic        ar_hs;
   logic        aw_have;
   logic        w_have;
   logic [3:0]  waddr;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic [31:0] ctrl_rd;
   logic [31:0] freq_rd;
   logic [31:0] stat_rd;
   logic [31:0] nv;
   logic [1:0]  chk;
   logic [2:0]  err_set;
   logic [2:0]  err_clr;
   logic        gap_done;

   always_comb begin
      next_r  = r;
      aw_hs   = s_axi_awvalid && r.awready;
      w_hs    = s_axi_wvalid && r.wready;
      ar_hs   = s_axi_arvalid && r.arready;
      aw_have = r.aw_got || aw_hs;
      w_have  = r.w_got || w_hs;
      waddr   = r.aw_got ? r.aw_addr : s_axi_awaddr;
      wd      = r.w_got ? r.wdata : s_axi_wdata;
      ws      = r.w_got ? r.wstrb : s_axi_wstrb;
      gap_done = (r.gap_cnt == 10'h000);
      err_set = 3'b000;
      err_clr = 3'b000;
      nv      = 32'h0000_0000;
      chk     = 2'b00;

      ctrl_rd = 32'h0000_0000;
      ctrl_rd[ccs_pkg::CTRL_SLOW_BIT] = r.slow_en;
      ctrl_rd[ccs_pkg::CTRL_FAST_BIT] = r.fast_en;
      ctrl_rd[ccs_pkg::CTRL_RNG_LO +: 2] = r.vrange;
      freq_rd = {16'h0000, r.tgt_khz};
      stat_rd = {5'h00, r.err, 5'h00, gap_done, r.seq != ccs_pkg::SEQ_IDLE, r.wait_state, r.cur_khz};

      if (aw_hs) begin
         next_r.aw_got  = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (w_hs) begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end

      // sequence runs one step per cycle
      case (r.seq)
         ccs_pkg::SEQ_IDLE: begin
            next_r.seq = ccs_pkg::SEQ_IDLE;
         end
         ccs_pkg::SEQ_RAISE: begin
            next_r.wait_state = r.wait_state | r.need_ws; // RULE_12
            next_r.seq = ccs_pkg::SEQ_SWITCH;
         end
         ccs_pkg::SEQ_SWITCH: begin
            next_r.cur_khz = r.tgt_khz;
            next_r.gap_cnt = ccs_pkg::GAP_LOAD;
            next_r.seq = ccs_pkg::SEQ_SETTLE;
         end
         ccs_pkg::SEQ_SETTLE: begin
            next_r.wait_state = r.need_ws; // RULE_12
            next_r.seq = ccs_pkg::SEQ_IDLE;
         end
         default: begin
            next_r.seq = ccs_pkg::SEQ_IDLE;
         end
      endcase
      if (!gap_done && (r.seq != ccs_pkg::SEQ_SWITCH)) begin
         next_r.gap_cnt = r.gap_cnt - 10'h001;
      end

      if (aw_have && w_have && !r.bvalid) begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp  = ccs_pkg::RESP_OKAY;
         case (waddr)
            ccs_pkg::ADDR_CTRL: begin
               nv = merge(ctrl_rd, wd, ws);
               next_r.slow_en = nv[ccs_pkg::CTRL_SLOW_BIT]; // RULE_06
               next_r.fast_en = nv[ccs_pkg::CTRL_FAST_BIT]; // RULE_09
               chk = ws_of(nv[ccs_pkg::CTRL_RNG_LO +: 2], r.cur_khz);
               // range may only change while the running clock fits it
               if (chk[0] && (chk[1] == r.wait_state) && r.seq == ccs_pkg::SEQ_IDLE) begin
                  next_r.vrange = nv[ccs_pkg::CTRL_RNG_LO +: 2];
               end else if (nv[ccs_pkg::CTRL_RNG_LO +: 2] != r.vrange) begin
                  err_set[2] = 1'b1;
               end
            end
            ccs_pkg::ADDR_FREQ: begin
               nv = merge(freq_rd, wd, ws);
               chk = ws_of(r.vrange, nv[15:0]);
               if (r.seq != ccs_pkg::SEQ_IDLE || !gap_done) begin
                  err_set[1] = 1'b1; // RULE_02
               end else if ({2'b00, nv[15:0]} >= {r.cur_khz, 2'b00}) begin
                  err_set[0] = 1'b1; // RULE_01
               end else if (!chk[0]) begin
                  err_set[2] = 1'b1;
               end else begin
                  next_r.tgt_khz = nv[15:0];
                  next_r.need_ws = chk[1];
                  next_r.seq = ccs_pkg::SEQ_RAISE;
               end
            end
            ccs_pkg::ADDR_STATUS: begin
               if (ws[ccs_pkg::ST_ERR_LO / 8]) begin
                  err_clr = wd[ccs_pkg::ST_ERR_LO +: 3];
               end
            end
            default: begin
               next_r.bresp = ccs_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      // a new error outlasts a clear in the same cycle
      next_r.err = (r.err & ~err_clr) | err_set;
      next_r.awready = !next_r.aw_got && !next_r.bvalid;
      next_r.wready  = !next_r.w_got && !next_r.bvalid;

      if (ar_hs) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = ccs_pkg::RESP_OKAY;
         case (s_axi_araddr)
            ccs_pkg::ADDR_CTRL: begin
               next_r.rdata = ctrl_rd;
            end
            ccs_pkg::ADDR_FREQ: begin
               next_r.rdata = freq_rd;
            end
            ccs_pkg::ADDR_STATUS: begin
               next_r.rdata = stat_rd;
            end
            default: begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = ccs_pkg::RESP_SLVERR;
            end
         endcase
      end else if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
      next_r.arready = !next_r.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r            <= '0;
         r.slow_en    <= 1'b0; // RULE_08
         r.fast_en    <= 1'b0; // RULE_10
         r.vrange     <= ccs_pkg::RST_RANGE;
         r.cur_khz    <= ccs_pkg::RST_KHZ;
         r.tgt_khz    <= ccs_pkg::RST_KHZ;
         r.seq        <= ccs_pkg::SEQ_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign s_axi_awready    = r.awready;
   assign s_axi_wready     = r.wready;
   assign s_axi_bvalid     = r.bvalid;
   assign s_axi_bresp      = r.bresp;
   assign s_axi_arready    = r.arready;
   assign s_axi_rvalid     = r.rvalid;
   assign s_axi_rdata      = r.rdata;
   assign s_axi_rresp      = r.rresp;
   assign core_khz         = r.cur_khz;
   assign flash_wait_state = r.wait_state;

   ccs_pin_mux u_slow_pins (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .osc_en    (r.slow_en), // RULE_07
      .gpio_out  (port_c_gpio_out),
      .gpio_oe   (port_c_gpio_oe),
      .pad_in    (port_c_pad_in),
      .osc_drive (slow_crystal_drive),
      .pins      (port_c_pins)
   );

   ccs_pin_mux u_fast_pins (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .osc_en    (r.fast_en), // RULE_11
      .gpio_out  (port_h_gpio_out),
      .gpio_oe   (port_h_gpio_oe),
      .pad_in    (port_h_pad_in),
      .osc_drive (fast_crystal_drive),
      .pins      (port_h_pins)
   );

endmodule

// ### verif/ccs_top_sva.sv
/*
 Checker for clock scaling and oscillator pins.
 Assumes binding to ccs_top, one clock domain.
*/
`timescale 1ns/100ps
module ccs_top_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [15:0] core_khz,
   input wire logic        flash_wait_state,
   input wire logic [1:0]  port_c_gpio_out,
   input wire logic [1:0]  port_c_gpio_oe,
   input wire logic [1:0]  port_c_pad_in,
   input wire logic        slow_crystal_drive,
   input ccs_pkg::ccs_pin_t port_c_pins,
   input wire logic [1:0]  port_h_gpio_out,
   input wire logic [1:0]  port_h_gpio_oe,
   input wire logic [1:0]  port_h_pad_in,
   input wire logic        fast_crystal_drive,
   input ccs_pkg::ccs_pin_t port_h_pins
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_khz_up;
      $changed(core_khz) && core_khz > 16'h3E80;
   endsequence
   sequence s_ws_drop;
      $fell(flash_wait_state);
   endsequence
   chk_slow_gpio:
   assert property ($past(aresetn) && !port_c_pins.osc_mode |-> port_c_pins.pad_oe == $past(port_c_gpio_oe)
      && port_c_pins.pad_out == $past(port_c_gpio_out) && port_c_pins.gpio_in == $past(port_c_pad_in))
      else $error("port c gpio passthrough wrong");
   chk_slow_osc:
   assert property (port_c_pins.osc_mode |-> port_c_pins.pad_oe == 2'b10 && port_c_pins.gpio_in == 2'b00
      && port_c_pins.pad_out == {$past(slow_crystal_drive), 1'b0} && port_c_pins.fast_crystal_input == $past(port_c_pad_in[0]))
      else $error("port c crystal mode wrong");
   chk_fast_gpio:
   assert property ($past(aresetn) && !port_h_pins.osc_mode |-> port_h_pins.pad_oe == $past(port_h_gpio_oe)
      && port_h_pins.pad_out == $past(port_h_gpio_out) && port_h_pins.gpio_in == $past(port_h_pad_in))
      else $error("port h gpio passthrough wrong");
   chk_fast_osc:
   assert property (port_h_pins.osc_mode |-> port_h_pins.pad_oe == 2'b10 && port_h_pins.gpio_in == 2'b00
      && port_h_pins.pad_out == {$past(fast_crystal_drive), 1'b0} && port_h_pins.fast_crystal_input == $past(port_h_pad_in[0]))
      else $error("port h crystal mode wrong");
   chk_reset_off:
   assert property ($rose(aresetn) |-> !port_c_pins.osc_mode && !port_h_pins.osc_mode
      && core_khz == 16'h0834 && !flash_wait_state)
      else $error("state after reset wrong");
   chk_ws_high:
   assert property (core_khz > 16'h3E80 |-> flash_wait_state) else $error("fast clock without wait state");
   chk_ws_low:
   assert property (core_khz <= 16'h0834 && $stable(core_khz) && $stable(flash_wait_state) |-> !flash_wait_state)
      else $error("slow clock with wait state");
   chk_ws_before:
   assert property (s_khz_up |-> $past(flash_wait_state) && $stable(flash_wait_state))
      else $error("wait state not raised before switch");
   chk_ws_after:
   assert property (s_ws_drop |-> $stable(core_khz) && core_khz <= 16'h3E80)
      else $error("wait state lowered too early");
endmodule
bind ccs_top ccs_top_sva i_ccs_top_sva (.aclk, .aresetn, .core_khz, .flash_wait_state, .port_c_gpio_out,
   .port_c_gpio_oe, .port_c_pad_in, .slow_crystal_drive, .port_c_pins, .port_h_gpio_out, .port_h_gpio_oe,
   .port_h_pad_in, .fast_crystal_drive, .port_h_pins);

// ### verif/ccs_xtal_model.sv
/*
 Crystal and board pins behind one pair of oscillator pins.
 Assumes pins come from the block's registered pin struct.
*/
`timescale 1ns/100ps
module ccs_xtal_model (
   input  wire logic        aclk,
   input  ccs_pkg::ccs_pin_t pins,
   input  wire logic [1:0]  ext,
   output logic [1:0]       pad_in,
   output logic             drive
);
   logic osc = 1'b0;
   always @(posedge aclk) begin
      osc <= ~osc;
   end
   assign drive = ~osc;
   // crystal only drives the input pin while the block hands it over
   assign pad_in[0] = pins.pad_oe[0] ? pins.pad_out[0] : (pins.osc_mode ? osc : ext[0]);
   assign pad_in[1] = pins.pad_oe[1] ? pins.pad_out[1] : ext[1];
endmodule

// ### verif/test_ccs_top.sv
/*
 Testbench for ccs_top: bus tasks, pin handover, frequency stepping.
 Assumes ccs_top, ccs_xtal_model and the checker compiled before.
*/
`timescale 1ns/100ps
module test_ccs_top;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [3:0]        s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp, port_c_pad_in, port_h_pad_in, ext = 2'b10;
   logic [1:0]        port_c_gpio_out = 2'h0, port_c_gpio_oe = 2'h0;
   logic [1:0]        port_h_gpio_out = 2'h0, port_h_gpio_oe = 2'h0;
   logic [15:0]       core_khz, cur;
   logic              flash_wait_state, slow_crystal_drive, fast_crystal_drive;
   ccs_pkg::ccs_pin_t port_c_pins, port_h_pins;
   int                n_fail = 0, checks_done = 0;

   ccs_top i_ccs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_khz,
      .flash_wait_state, .port_c_gpio_out, .port_c_gpio_oe, .port_c_pad_in, .slow_crystal_drive, .port_c_pins,
      .port_h_gpio_out, .port_h_gpio_oe, .port_h_pad_in, .fast_crystal_drive, .port_h_pins);
   ccs_xtal_model i_xtal_c (.aclk, .pins(port_c_pins), .ext, .pad_in(port_c_pad_in), .drive(slow_crystal_drive));
   ccs_xtal_model i_xtal_h (.aclk, .pins(port_h_pins), .ext, .pad_in(port_h_pad_in), .drive(fast_crystal_drive));

   always #2.5 aclk = ~aclk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(er));
   endtask

   // waits g cycles first so a zero gap can provoke the spacing refusal
   task automatic fq(input int g, input logic [15:0] k, input logic [2:0] e, input logic w);
      logic [31:0] v;
      repeat (g) @(posedge aclk);
      wr(ccs_pkg::ADDR_FREQ, {16'h0, k}, ccs_pkg::RESP_OKAY);
      repeat (6) @(posedge aclk);
      if (e == 3'h0) cur = k;
      rd(ccs_pkg::ADDR_STATUS, v, ccs_pkg::RESP_OKAY);
      chk(v & 32'h0701_FFFF, {5'h0, e, 7'h0, w, cur});
      chk({15'h0, flash_wait_state, core_khz}, {15'h0, w, cur});
      wr(ccs_pkg::ADDR_STATUS, 32'h0700_0000, ccs_pkg::RESP_OKAY);
   endtask

   task automatic rst;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      rst();
      port_c_gpio_out <= 2'b01;
      port_c_gpio_oe <= 2'b01;
      port_h_gpio_out <= 2'b01;
      port_h_gpio_oe <= 2'b01;
      repeat (3) @(posedge aclk);
      chk(32'(port_c_pins), 32'h5C);
      chk(32'(port_h_pins), 32'h5C);
      rd(ccs_pkg::ADDR_CTRL, d, ccs_pkg::RESP_OKAY);
      chk(d & 32'hF, 32'h4);
      // gpio still asks to drive pin 14: crystal mode must win
      wr(ccs_pkg::ADDR_CTRL, 32'h5, ccs_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(32'(port_c_pins) & 32'h3D, 32'h21);
      chk(32'(port_h_pins), 32'h5C);
      wr(ccs_pkg::ADDR_CTRL, 32'h6, ccs_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(32'(port_c_pins), 32'h5C);
      chk(32'(port_h_pins) & 32'h3D, 32'h21);
      rst();
      chk(32'(port_c_pins), 32'h5C);
      chk(32'(port_h_pins), 32'h5C);
      $display("test pins done");
      wr(4'hC, 32'h1, ccs_pkg::RESP_SLVERR);
      rd(4'hC, d, ccs_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      $display("test bus done");
      cur = 16'h0834;
      fq(1010, 16'h1F40, 3'h0, 1'b0);
      fq(0, 16'h3E80, 3'h2, 1'b0);
      fq(1010, 16'h7D00, 3'h1, 1'b0);
      fq(1010, 16'h3E80, 3'h0, 1'b0);
      fq(1010, 16'h7D00, 3'h0, 1'b1);
      fq(1010, 16'h1F40, 3'h0, 1'b0);
      wr(ccs_pkg::ADDR_CTRL, 32'h8, ccs_pkg::RESP_OKAY);
      fq(1010, 16'h3E80, 3'h0, 1'b1);
      fq(1010, 16'h4E20, 3'h4, 1'b1);
      fq(1010, 16'h0FA0, 3'h0, 1'b0);
      // range 3 is only accepted once the running clock fits it at the present wait state
      fq(1010, 16'h0834, 3'h0, 1'b0);
      wr(ccs_pkg::ADDR_CTRL, 32'hC, ccs_pkg::RESP_OKAY);
      fq(1010, 16'h1068, 3'h0, 1'b1);
      fq(1010, 16'h1388, 3'h4, 1'b1);
      fq(1010, 16'h0834, 3'h0, 1'b0);
      fq(1010, 16'h001F, 3'h4, 1'b0);
      $display("test freq done");
      end_of_test();
   end
endmodule
